/* File: design/lgtj_regs.v */
// global configuration and per-channel termination/jitter register bank of a dual-channel line interface
`timescale 1ns/1ps
`default_nettype none
`include "lgtj_defines.vh"
module lgtj_regs #(
  parameter integer SETTLE_CYC = (`LGTJ_STD_SETTLE_NS + `LGTJ_CLK_PERIOD_NS - 1) / `LGTJ_CLK_PERIOD_NS
) (
  input  wire       clk_sys_i,        // system clock, 250 MHz
  input  wire       rst_i,            // hard reset, sync active high
  input  wire       wr_i,             // register write strobe, one cycle
  input  wire       rd_i,             // register read strobe, one cycle
  input  wire [5:0] addr_i,           // register address
  input  wire [7:0] wdata_i,          // write data
  output reg  [7:0] rdata_o,          // read data, valid cycle after rd_i
  input  wire [1:0] ch_irq_pend_i,    // unmasked pending interrupt per channel
  output wire       irq_pin_o,        // interrupt pin level
  output wire       irq_pin_oe_o,     // interrupt pin output enable
  output reg        drv_hiz_o,        // all line drivers high impedance
  input  wire       drv_release_i,    // leave high impedance once transmit set up
  output wire [1:0] monitor_mode_o,   // 0 normal, 1 ch2 rx, 2 ch2 tx into rx1
  output wire       t1_mode_o,        // 1 T1/J1, 0 E1 for all channels
  output wire       std_settling_o,   // high during line-standard settle wait
  output wire [5:0] ch1_tx_rx_term_o, // ch1 {tx sel[2:0], rx sel[2:0]}
  output wire [5:0] ch2_tx_rx_term_o, // ch2 {tx sel[2:0], rx sel[2:0]}
  output wire [1:0] ch1_ja_path_o,    // ch1 attenuator placement
  output wire [1:0] ch2_ja_path_o,    // ch2 attenuator placement
  output wire [7:0] ch1_ja_depth_o,   // ch1 elastic depth bits
  output wire [7:0] ch2_ja_depth_o,   // ch2 elastic depth bits
  output wire [1:0] attenuator_limit_mode_o,       // per-channel limit mode
  output wire [1:0] ja_bw_narrow_o    // per-channel narrow bandwidth
);
  localparam [15:0] SETTLE_N = SETTLE_CYC[15:0];
  wire soft_rst_hit = wr_i & (addr_i == `LGTJ_OFF_SOFT_RESET);
  reg  soft_rst_q;
  wire bank_rst = rst_i | soft_rst_q;
  reg  [7:0] gcf_q;
  reg        std_q;
  reg [15:0] settle_cnt_q;
  reg  [1:0] irq_src_q;
  reg        irq_act_q;
  wire [5:0] term1, term2, ja1, ja2;
  wire       bcast = gcf_q[`LGTJ_GCF_BCAST];
  wire w_t1 = wr_i & (addr_i == `LGTJ_OFF_TERM_CH1);
  wire w_t2 = wr_i & (addr_i == `LGTJ_OFF_TERM_CH2);
  wire w_j1 = wr_i & (addr_i == `LGTJ_OFF_JA_CH1);
  wire w_j2 = wr_i & (addr_i == `LGTJ_OFF_JA_CH2);
  wire t1_we = w_t1 | (bcast & w_t2);
  wire t2_we = w_t2 | (bcast & w_t1);
  wire j1_we = w_j1 | (bcast & w_j2);
  wire j2_we = w_j2 | (bcast & w_j1);
  // soft reset takes effect for one cycle after the write strobe
  always @(posedge clk_sys_i) begin
    if (rst_i)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= soft_rst_hit;
  end
  always @(posedge clk_sys_i) begin
    if (bank_rst)
      gcf_q <= `LGTJ_RST_GLOBAL_CFG;
    else if (wr_i && addr_i == `LGTJ_OFF_GLOBAL_CFG)
      gcf_q <= {wdata_i[7:6], 1'b0, 1'b0, wdata_i[3:0]};
  end
  // line standard is kept apart so the soft reset does not clear it
  always @(posedge clk_sys_i) begin
    if (rst_i)
      std_q <= 1'b0;
    else if (wr_i && addr_i == `LGTJ_OFF_GLOBAL_CFG)
      std_q <= wdata_i[`LGTJ_GCF_STD];
  end
  always @(posedge clk_sys_i) begin
    if (rst_i)
      settle_cnt_q <= 16'h0000;
    else if (wr_i && addr_i == `LGTJ_OFF_GLOBAL_CFG && wdata_i[`LGTJ_GCF_STD] != std_q)
      settle_cnt_q <= SETTLE_N;
    else if (settle_cnt_q != 16'h0000)
      settle_cnt_q <= settle_cnt_q - 16'h0001;
  end
  assign std_settling_o = (settle_cnt_q != 16'h0000);
  assign t1_mode_o      = std_q;
  assign monitor_mode_o = (gcf_q[`LGTJ_GCF_MON_LO] == 1'b0) ? 2'h0 :
                          (gcf_q[`LGTJ_GCF_MON_HI] ? 2'h2 : 2'h1);
  // drivers float after any reset until the transmit side releases them
  always @(posedge clk_sys_i) begin
    if (bank_rst)
      drv_hiz_o <= 1'b1;
    else if (drv_release_i)
      drv_hiz_o <= 1'b0;
  end
  // source latch: active low per channel, follows pending while enabled
  always @(posedge clk_sys_i) begin
    if (bank_rst) begin
      irq_src_q <= 2'b11;
      irq_act_q <= 1'b0;
    end else begin
      irq_src_q <= gcf_q[`LGTJ_GCF_IRQ_DIS] ? 2'b11 : ~ch_irq_pend_i;
      irq_act_q <= ~gcf_q[`LGTJ_GCF_IRQ_DIS] & (|ch_irq_pend_i);
    end
  end
  // pin style: open drain pulls low only when active, push-pull always drives
  assign irq_pin_oe_o = gcf_q[`LGTJ_GCF_PIN_LO] ? 1'b1 : irq_act_q;
  assign irq_pin_o    = (gcf_q[`LGTJ_GCF_PIN_HI] & gcf_q[`LGTJ_GCF_PIN_LO]) ? irq_act_q : ~irq_act_q;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `LGTJ_OFF_SOFT_RESET: rdata_o <= `LGTJ_RST_SOFT_RESET;
        `LGTJ_OFF_GLOBAL_CFG: rdata_o <= {gcf_q[7:5], std_q, gcf_q[3:0]};
        `LGTJ_OFF_IRQ_CH_SRC: rdata_o <= {6'b000000, irq_src_q};
        `LGTJ_OFF_TERM_CH1:   rdata_o <= {2'b00, term1};
        `LGTJ_OFF_TERM_CH2:   rdata_o <= {2'b00, term2};
        `LGTJ_OFF_JA_CH1:     rdata_o <= {2'b00, ja1};
        `LGTJ_OFF_JA_CH2:     rdata_o <= {2'b00, ja2};
        default:              rdata_o <= 8'h00;
      endcase
    end
  end
  lgtj_chan_cfg u_ch1 (
    .clk_sys_i       (clk_sys_i),
    .rst_i           (bank_rst),
    .term_we_i       (t1_we),
    .ja_we_i         (j1_we),
    .wdata_i         (wdata_i),
    .term_o          (term1),
    .ja_o            (ja1),
    .tx_term_sel_o   (ch1_tx_rx_term_o[5:3]),
    .rx_term_sel_o   (ch1_tx_rx_term_o[2:0]),
    .ja_path_o       (ch1_ja_path_o),
    .ja_depth_bits_o (ch1_ja_depth_o),
    .attenuator_limit_mode_o      (attenuator_limit_mode_o[0]),
    .ja_bw_narrow_o  (ja_bw_narrow_o[0])
  );
  lgtj_chan_cfg u_ch2 (
    .clk_sys_i       (clk_sys_i),
    .rst_i           (bank_rst),
    .term_we_i       (t2_we),
    .ja_we_i         (j2_we),
    .wdata_i         (wdata_i),
    .term_o          (term2),
    .ja_o            (ja2),
    .tx_term_sel_o   (ch2_tx_rx_term_o[5:3]),
    .rx_term_sel_o   (ch2_tx_rx_term_o[2:0]),
    .ja_path_o       (ch2_ja_path_o),
    .ja_depth_bits_o (ch2_ja_depth_o),
    .attenuator_limit_mode_o      (attenuator_limit_mode_o[1]),
    .ja_bw_narrow_o  (ja_bw_narrow_o[1])
  );
endmodule // lgtj_regs
`default_nettype wire

/* File: design/lgtj_defines.vh */
// register offsets, field positions, reset values and timing counts of the global/termination/jitter bank
`ifndef LGTJ_DEFINES_VH
`define LGTJ_DEFINES_VH
`define LGTJ_ADDR_W            6
`define LGTJ_OFF_SOFT_RESET    6'h01
`define LGTJ_OFF_TERM_CH1      6'h02
`define LGTJ_OFF_JA_CH1        6'h03
`define LGTJ_OFF_TERM_CH2      6'h22
`define LGTJ_OFF_JA_CH2        6'h23
`define LGTJ_OFF_GLOBAL_CFG    6'h20
`define LGTJ_OFF_IRQ_CH_SRC    6'h21
`define LGTJ_RST_SOFT_RESET    8'h00
`define LGTJ_RST_GLOBAL_CFG    8'h04
`define LGTJ_RST_TERM          6'h00
`define LGTJ_RST_JA            6'h20
`define LGTJ_GCF_MON_HI        7
`define LGTJ_GCF_MON_LO        6
`define LGTJ_GCF_STD           4
`define LGTJ_GCF_BCAST         3
`define LGTJ_GCF_IRQ_DIS       2
`define LGTJ_GCF_PIN_HI        1
`define LGTJ_GCF_PIN_LO        0
`define LGTJ_ATTENUATOR_LIMIT_MODE          5
`define LGTJ_JA_PLACE_HI       4
`define LGTJ_JA_PLACE_LO       3
`define LGTJ_JA_DEPTH_HI       2
`define LGTJ_JA_DEPTH_LO       1
`define LGTJ_JA_BW             0
`define LGTJ_STD_SETTLE_NS     50000
`define LGTJ_CLK_PERIOD_NS     4
`endif

/* File: design/lgtj_chan_cfg.v */
// per-channel termination and jitter attenuator configuration with decoded outputs
`timescale 1ns/1ps
`default_nettype none
`include "lgtj_defines.vh"
module lgtj_chan_cfg (
  input  wire       clk_sys_i,      // system clock
  input  wire       rst_i,          // hard or soft reset, sync active high
  input  wire       term_we_i,      // write strobe for termination register
  input  wire       ja_we_i,        // write strobe for attenuator register
  input  wire [7:0] wdata_i,        // write data
  output wire [5:0] term_o,         // stored termination bits
  output wire [5:0] ja_o,           // stored attenuator bits
  output reg  [2:0] tx_term_sel_o,  // 0..3 internal 75/120/100/110, 4 external
  output reg  [2:0] rx_term_sel_o,  // 0..3 internal 75/120/100/110, 4 external
  output reg  [1:0] ja_path_o,      // 0 unused, 1 transmit, 2 receive
  output reg  [7:0] ja_depth_bits_o,// elastic buffer depth in bits
  output reg        attenuator_limit_mode_o,     // limit mode
  output reg        ja_bw_narrow_o  // narrow jitter bandwidth
);
  reg [5:0] term_q;
  reg [5:0] ja_q;
  assign term_o = term_q;
  assign ja_o   = ja_q;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      term_q <= `LGTJ_RST_TERM;
      ja_q   <= `LGTJ_RST_JA;
    end else begin
      if (term_we_i)
        term_q <= wdata_i[5:0];
      if (ja_we_i)
        ja_q <= wdata_i[5:0];
    end
  end
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_term_sel_o   <= 3'h0;
      rx_term_sel_o   <= 3'h0;
      ja_path_o       <= 2'h0;
      ja_depth_bits_o <= 8'h80;
      attenuator_limit_mode_o      <= 1'b1;
      ja_bw_narrow_o  <= 1'b0;
    end else begin
      tx_term_sel_o  <= term_q[5] ? 3'h4 : {1'b0, term_q[4:3]};
      rx_term_sel_o  <= term_q[2] ? 3'h4 : {1'b0, term_q[1:0]};
      attenuator_limit_mode_o     <= ja_q[`LGTJ_ATTENUATOR_LIMIT_MODE];
      ja_bw_narrow_o <= ja_q[`LGTJ_JA_BW];
      case (ja_q[`LGTJ_JA_PLACE_HI:`LGTJ_JA_PLACE_LO])
        2'b01:   ja_path_o <= 2'h1;
        2'b11:   ja_path_o <= 2'h2;
        default: ja_path_o <= 2'h0;
      endcase
      case (ja_q[`LGTJ_JA_DEPTH_HI:`LGTJ_JA_DEPTH_LO])
        2'b00:   ja_depth_bits_o <= 8'h80;
        2'b01:   ja_depth_bits_o <= 8'h40;
        default: ja_depth_bits_o <= 8'h20;
      endcase
    end
  end
endmodule // lgtj_chan_cfg
`default_nettype wire

/* File: tb/lgtj_regs_assertions.sv */
// assertion checker for the register bank
`timescale 1ns/1ps
`default_nettype none
module lgtj_regs_chk (
  input wire logic       clk_sys_i,      // clock
  input wire logic       rst_i,          // reset
  input wire logic       wr_i,           // write
  input wire logic       rd_i,           // read
  input wire logic [5:0] addr_i,         // address
  input wire logic [7:0] wdata_i,        // write data
  input wire logic [7:0] rdata_o,        // read data
  input wire logic [1:0] ch_irq_pend_i,  // pending
  input wire logic       irq_pin_o,      // pin
  input wire logic       irq_pin_oe_o,   // pin enable
  input wire logic       drv_hiz_o,      // drivers off
  input wire logic [1:0] monitor_mode_o, // monitor
  input wire logic       t1_mode_o,      // standard
  input wire logic       std_settling_o  // settling
);
  logic [7:0] gcf_q;
  logic       act;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // shadow of the global config as the host sees it
  always_ff @(posedge clk_sys_i)
    if (rst_i) gcf_q <= 8'h04;
    else if (wr_i && addr_i == 6'h20) gcf_q <= wdata_i & 8'hDF;
    else if (wr_i && addr_i == 6'h01) gcf_q <= 8'h04 | (gcf_q & 8'h10);
  assign act = gcf_q[0] ? (gcf_q[1] ? irq_pin_o : !irq_pin_o) : irq_pin_oe_o;
  sequence s_st;
    gcf_q == $past(gcf_q) && gcf_q == $past(gcf_q, 2) && gcf_q == $past(gcf_q, 3);
  endsequence
  property p_srst_hiz; wr_i && addr_i == 6'h01 |-> ##[1:3] drv_hiz_o; endproperty
  a_srst_hiz: assert property (p_srst_hiz) else $error("drivers on after soft reset");
  property p_srst_rd; rd_i && addr_i == 6'h01 |=> rdata_o == 8'h00; endproperty
  a_srst_rd: assert property (p_srst_rd) else $error("soft reset reg not zero");
  property p_chsrc; rd_i && addr_i == 6'h21 |=> rdata_o[7:2] == 6'h00; endproperty
  a_chsrc: assert property (p_chsrc) else $error("source reg upper bits set");
  property p_irq; s_st |-> act == (!gcf_q[2] && (|$past(ch_irq_pend_i))); endproperty
  a_irq: assert property (p_irq) else $error("irq pin level wrong");
  property p_oe; s_st and gcf_q[0] |-> irq_pin_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("push-pull pin not driven");
  property p_std; wr_i && addr_i == 6'h20 && wdata_i[4] != t1_mode_o |-> ##[1:2] std_settling_o; endproperty
  a_std: assert property (p_std) else $error("no settle wait");
  property p_keep; wr_i && addr_i == 6'h01 |=> $stable(t1_mode_o) [*3]; endproperty
  a_keep: assert property (p_keep) else $error("standard lost on soft reset");
  property p_mon; s_st |-> monitor_mode_o == (gcf_q[6] ? (gcf_q[7] ? 2'd2 : 2'd1) : 2'd0); endproperty
  a_mon: assert property (p_mon) else $error("monitor mode wrong");
  property p_t1; s_st |-> t1_mode_o == gcf_q[4]; endproperty
  a_t1: assert property (p_t1) else $error("line standard wrong");
endmodule // lgtj_regs_chk
bind lgtj_regs lgtj_regs_chk chk_u (.clk_sys_i, .rst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
  .ch_irq_pend_i, .irq_pin_o, .irq_pin_oe_o, .drv_hiz_o, .monitor_mode_o, .t1_mode_o, .std_settling_o);
`default_nettype wire

/* File: tb/lgtj_host.sv */
// host processor model on the register port
`timescale 1ns/1ps
`default_nettype none
module lgtj_host (
  input  wire logic       clk_sys_i, // clock
  input  wire logic       busy_i,    // settle wait running
  input  wire logic [7:0] rdata_i,   // read data
  output var  logic       wr_o,      // write strobe
  output var  logic       rd_o,      // read strobe
  output var  logic [5:0] addr_o,    // address
  output var  logic [7:0] wdata_o    // write data
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 6'h00;
    wdata_o = 8'h00;
  end
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    // two idle cycles cover the soft reset, then wait out any settle count
    repeat (2) @(negedge clk_sys_i);
    while (busy_i) @(negedge clk_sys_i);
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_sys_i);
    d = rdata_i;
  endtask
endmodule // lgtj_host
`default_nettype wire

/* File: tb/tb_lgtj_regs.sv */
// self-checking testbench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_lgtj_regs;
  logic       clk_sys_i, wr_i, rd_i, irq_pin_o, irq_pin_oe_o, drv_hiz_o, t1_mode_o, std_settling_o;
  logic       rst_i = 1'b1;
  logic       drv_release_i = 1'b0;
  logic [1:0] pend = 2'b00;
  logic [1:0] path1, path2, lim, bw, mon;
  logic [5:0] addr_i, term1, term2;
  logic [7:0] wdata_i, rdata_o, dep1, dep2, d;
  int         n_errors = 0;
  int         n_compared = 0;
  logic [21:0] rows [7] = '{{6'h02, 8'hFF, 8'h3F}, {6'h22, 8'h07, 8'h07}, {6'h03, 8'hFF, 8'h3F},
    {6'h23, 8'h15, 8'h15}, {6'h20, 8'hE4, 8'hC4}, {6'h21, 8'hFF, 8'h03}, {6'h20, 8'h44, 8'h44}};
  lgtj_regs #(.SETTLE_CYC(10)) dut_u (.clk_sys_i, .rst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
    .ch_irq_pend_i(pend), .irq_pin_o, .irq_pin_oe_o, .drv_hiz_o, .drv_release_i, .monitor_mode_o(mon),
    .t1_mode_o, .std_settling_o, .ch1_tx_rx_term_o(term1), .ch2_tx_rx_term_o(term2), .ch1_ja_path_o(path1),
    .ch2_ja_path_o(path2), .ch1_ja_depth_o(dep1), .ch2_ja_depth_o(dep2), .attenuator_limit_mode_o(lim), .ja_bw_narrow_o(bw));
  lgtj_host host_u (.clk_sys_i, .busy_i(std_settling_o), .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    host_u.rd_reg(a, d);
    chk("read", d, e);
  endtask
  task automatic hrst;
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
  endtask
  task results;
    $display("errors %0d of %0d checks", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #40000;
    n_errors++;
    results();
  end
  initial begin
    hrst();
    foreach (rows[i]) begin
      host_u.wr_reg(rows[i][21:16], rows[i][15:8]);
      rc(rows[i][21:16], rows[i][7:0]);
    end
    chk("mon", {6'h00, mon}, 8'h01);
    hrst();
    rc(6'h20, 8'h04);
    chk("mon_rst", {6'h00, mon}, 8'h00);
    chk("hiz_rst", {7'h00, drv_hiz_o}, 8'h01);
    rc(6'h03, 8'h20);
    host_u.wr_reg(6'h20, 8'h08);
    host_u.wr_reg(6'h02, 8'h2A);
    rc(6'h22, 8'h2A);
    chk("term2", {2'b00, term2}, 8'h22);
    chk("term1", {2'b00, term1}, 8'h22);
    host_u.wr_reg(6'h23, 8'h1D);
    rc(6'h03, 8'h1D);
    chk("ja1", {path1, lim, bw, 2'b00}, 8'h8C);
    chk("depth1", dep1, 8'h20);
    chk("path2", {6'h00, path2}, 8'h02);
    chk("depth2", dep2, 8'h20);
    @(posedge clk_sys_i);
    pend <= 2'b10;
    rc(6'h21, 8'h01);
    chk("od", {6'h00, irq_pin_oe_o, irq_pin_o}, 8'h02);
    host_u.wr_reg(6'h20, 8'h0B);
    chk("pp_high", {6'h00, irq_pin_oe_o, irq_pin_o}, 8'h03);
    host_u.wr_reg(6'h20, 8'h09);
    chk("pp_low", {6'h00, irq_pin_oe_o, irq_pin_o}, 8'h02);
    host_u.wr_reg(6'h20, 8'h0C);
    rc(6'h21, 8'h03);
    chk("off", {7'h00, irq_pin_oe_o}, 8'h00);
    @(posedge clk_sys_i);
    drv_release_i <= 1'b1;
    pend <= 2'b00;
    @(posedge clk_sys_i);
    drv_release_i <= 1'b0;
    host_u.wr_reg(6'h20, 8'h10);
    chk("hiz", {7'h00, drv_hiz_o}, 8'h00);
    chk("t1", {7'h00, t1_mode_o}, 8'h01);
    host_u.wr_reg(6'h01, 8'h5A);
    chk("hiz", {7'h00, drv_hiz_o}, 8'h01);
    rc(6'h20, 8'h14);
    rc(6'h03, 8'h20);
    rc(6'h01, 8'h00);
    results();
  end
endmodule // tb_lgtj_regs
`default_nettype wire
